// *** src/ieb_interrupt_enable_bank.sv ***
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ieb_interrupt_enable_bank
  import ieb_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [63:0]           src_event,
  output logic      [63:0]           req_out,
  output logic      [2:0]            irq_level,
  output logic                       irq
);

  if (ADDR_WIDTH < 7) begin : g_check
    $error("ADDR_WIDTH must be at least 7");
  end

  logic [63:0] en_reg;
  logic [63:0] en_next;
  logic [63:0] flag_reg;
  logic [63:0] flag_next;
  logic [2:0]  prio_reg [IEB_SOURCES];
  logic [2:0]  prio_next [IEB_SOURCES];
  logic [63:0] req_reg;
  logic [63:0] req_next;
  logic [2:0]  lvl_reg;
  logic [2:0]  lvl_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [63:0] prio_live;

  logic        mapped;
  logic [3:0]  idx;
  logic        setup_rd;
  logic        acc_wr;
  logic [1:0]  grp;
  logic [2:0]  pword;

  assign idx      = paddr[5:2];
  assign grp      = paddr[3:2];
  assign pword    = paddr[4:2];
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:6] == '0);
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr   = psel && penable && pwrite && mapped;

  // Zero-wait slave; read data was captured during the setup cycle
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_reg;

  always_comb begin
    for (int i = 0; i < IEB_SOURCES; i++) begin
      prio_live[i] = (prio_reg[i] != IEB_PRIO_OFF);
    end
  end

  // Enable registers
  always_comb begin
    en_next = en_reg;
    if (acc_wr && idx[3:2] == IEB_IDX_EN_FIRST[3:2]) begin
      en_next[16*grp +: 16] = pwdata[15:0] & IEB_IMPL_ALL[16*grp +: 16];
    end
  end

  // Flags: an event wins over a same-cycle write-one clear
  always_comb begin
    logic [63:0] clr;
    clr = '0;
    if (acc_wr && idx[3:2] == IEB_IDX_FLAG_FIRST[3:2]) begin
      clr[16*grp +: 16] = pwdata[15:0];
    end
    flag_next = ((flag_reg & ~clr) | src_event) & IEB_IMPL_ALL;
  end

  // Priority fields, one nibble per source
  always_comb begin
    for (int i = 0; i < IEB_SOURCES; i++) begin
      prio_next[i] = prio_reg[i];
    end
    if (acc_wr && idx[3] == IEB_IDX_PRIO_FIRST[3]) begin
      for (int n = 0; n < IEB_PRIO_WORDS; n++) begin
        prio_next[8*pword + n] = pwdata[IEB_PRIO_NIB*n +: IEB_PRIO_W];
      end
    end
  end

  // Forwarded requests and highest pending level
  always_comb begin
    req_next = flag_reg & en_reg & prio_live & IEB_IMPL_ALL;
    lvl_next = IEB_PRIO_OFF;
    for (int i = 0; i < IEB_SOURCES; i++) begin
      if (req_next[i] && prio_reg[i] > lvl_next) begin
        lvl_next = prio_reg[i];
      end
    end
  end

  // Read data mux, sampled in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    if (setup_rd) begin
      rdata_next = 32'h0000_0000;
      if (mapped) begin
        if (idx[3:2] == IEB_IDX_EN_FIRST[3:2]) begin
          rdata_next[15:0] = en_reg[16*grp +: 16] & IEB_IMPL_ALL[16*grp +: 16];
        end else if (idx[3:2] == IEB_IDX_FLAG_FIRST[3:2]) begin
          rdata_next[15:0] = flag_reg[16*grp +: 16];
        end else begin
          for (int n = 0; n < IEB_PRIO_WORDS; n++) begin
            rdata_next[IEB_PRIO_NIB*n +: IEB_PRIO_W] =
              prio_reg[8*pword + n] & {IEB_PRIO_W{IEB_IMPL_ALL[8*pword + n]}};
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg    <= {4{IEB_EN_RESET}};
      flag_reg  <= {4{IEB_FLAG_RESET}};
      req_reg   <= 64'h0;
      lvl_reg   <= IEB_PRIO_OFF;
      rdata_reg <= 32'h0;
      for (int i = 0; i < IEB_SOURCES; i++) begin
        prio_reg[i] <= IEB_PRIO_RESET;
      end
    end else begin
      en_reg    <= en_next;
      flag_reg  <= flag_next;
      req_reg   <= req_next;
      lvl_reg   <= lvl_next;
      rdata_reg <= rdata_next;
      for (int i = 0; i < IEB_SOURCES; i++) begin
        prio_reg[i] <= prio_next[i];
      end
    end
  end

  assign req_out   = req_reg;
  assign irq_level = lvl_reg;
  assign irq       = |req_reg;

  // Checks
  sequence s_en_write;
    psel && penable && pwrite && mapped && idx[3:2] == 2'h0;
  endsequence

  sequence s_flag_write;
    psel && penable && pwrite && mapped && idx[3:2] == 2'h1;
  endsequence

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (req_out == $past(flag_reg & en_reg & prio_live));
  endproperty
  a_gate: assert property (p_gate) else $error("request not flag AND enable");

  property p_en_write;
    @(posedge pclk) disable iff (!presetn)
      s_en_write |=> (en_reg[16*$past(grp) +: 16] == ($past(pwdata[15:0]) &
                      IEB_IMPL_ALL[16*$past(grp) +: 16]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_unimpl;
    @(posedge pclk) disable iff (!presetn)
      (en_reg & ~IEB_IMPL_ALL) == 64'h0 && (flag_reg & ~IEB_IMPL_ALL) == 64'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_read_zero;
    @(posedge pclk) disable iff (!presetn)
      (setup_rd && mapped && idx[3:2] == 2'h0) |=>
        prdata[31:16] == 16'h0 && (prdata[15:0] & ~IEB_IMPL_ALL[16*$past(grp) +: 16]) == 16'h0;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unimplemented bit read one");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((flag_reg & $past(src_event & IEB_IMPL_ALL)) == $past(src_event & IEB_IMPL_ALL));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_en_keeps_flag;
    @(posedge pclk) disable iff (!presetn)
      (s_en_write ##0 src_event == 64'h0) |=> $stable(flag_reg);
  endproperty
  a_en_keeps_flag: assert property (p_en_keeps_flag) else $error("enable write moved flag");

  property p_prio_off;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (req_out & ~$past(prio_live)) == 64'h0;
  endproperty
  a_prio_off: assert property (p_prio_off) else $error("zero priority forwarded");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (s_flag_write ##0 src_event == 64'h0) |=>
        (flag_reg[16*$past(grp) +: 16] & $past(pwdata[15:0])) == 16'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (flag_reg & en_reg & prio_live) != 64'h0 |=> irq ##0 irq_level != 3'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("pending source gave no interrupt");

  property p_map;
    @(posedge pclk) disable iff (!presetn)
      (IEB_IMPL_G1[8] == 1'b0 && IEB_IMPL_G1[5] == 1'b0 && IEB_IMPL_G2[4:2] == 3'h0 &&
       IEB_IMPL_G1[UART2_TRANSMIT_ENABLE] && IEB_IMPL_G2[PARALLEL_PORT_ENABLE] &&
       IEB_IMPL_G3[CALENDAR_CLOCK_ENABLE] && IEB_IMPL_G4[CHARGE_TIME_ENABLE]);
  endproperty
  a_map: assert property (p_map) else $error("bit map wrong");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      !(acc_wr && idx[3:2] == 2'h1) |=> (flag_reg & $past(flag_reg)) == $past(flag_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_en_hold;
    @(posedge pclk) disable iff (!presetn)
      !(acc_wr && idx[3:2] == 2'h0) |=> $stable(en_reg);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable moved");

  property p_flag_keeps_en;
    @(posedge pclk) disable iff (!presetn)
      s_flag_write |=> $stable(en_reg);
  endproperty
  a_flag_keeps_en: assert property (p_flag_keeps_en) else $error("enable moved");

  property p_read_en;
    @(posedge pclk) disable iff (!presetn)
      (setup_rd && mapped && idx[3:2] == 2'h0) |=>
        prdata == {16'h0, $past(en_reg[16*grp +: 16])};
  endproperty
  a_read_en: assert property (p_read_en) else $error("enable read wrong");

  property p_read_flag;
    @(posedge pclk) disable iff (!presetn)
      (setup_rd && mapped && idx[3:2] == 2'h1) |=>
        prdata == {16'h0, $past(flag_reg[16*grp +: 16])};
  endproperty
  a_read_flag: assert property (p_read_flag) else $error("flag read wrong");

  property p_prdata_hold;
    @(posedge pclk) disable iff (!presetn)
      !setup_rd |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");

  property p_quiet;
    @(posedge pclk) disable iff (!presetn)
      !irq |-> req_out == 64'h0 && irq_level == IEB_PRIO_OFF;
  endproperty
  a_quiet: assert property (p_quiet) else $error("level without request");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
      irq |-> irq_level != IEB_PRIO_OFF;
  endproperty
  a_level: assert property (p_level) else $error("interrupt at level zero");

  property p_prio_pad;
    @(posedge pclk) disable iff (!presetn)
      (setup_rd && mapped && idx[3] == 1'b1) |=> (prdata & 32'h8888_8888) == 32'h0;
  endproperty
  a_prio_pad: assert property (p_prio_pad) else $error("priority pad read one");

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !mapped) |=> $stable(en_reg);
  endproperty
  a_drop: assert property (p_drop) else $error("unmapped write landed");

  property p_void;
    @(posedge pclk) disable iff (!presetn)
      (setup_rd && !mapped) |=> prdata == 32'h0;
  endproperty
  a_void: assert property (p_void) else $error("unmapped read not zero");

  sequence s_hit;
    !acc_wr && (src_event & en_reg & prio_live & IEB_IMPL_ALL) != 64'h0;
  endsequence

  sequence s_quiet;
    !acc_wr;
  endsequence

  property p_hit;
    @(posedge pclk) disable iff (!presetn)
      s_hit ##1 s_quiet |=> irq;
  endproperty
  a_hit: assert property (p_hit) else $error("event not forwarded");

endmodule
`default_nettype wire

// *** src/ieb_pkg.sv ***
package ieb_pkg;

  localparam int          IEB_GROUPS     = 4;
  localparam int          IEB_SOURCES    = 64;
  localparam int          IEB_PRIO_W     = 3;
  localparam int          IEB_PRIO_WORDS = 8;
  localparam int          IEB_PRIO_NIB   = 4;

  localparam logic [15:0] IEB_IMPL_G1 = 16'hfedf;
  localparam logic [15:0] IEB_IMPL_G2 = 16'h3fe3;
  localparam logic [15:0] IEB_IMPL_G3 = 16'h4066;
  localparam logic [15:0] IEB_IMPL_G4 = 16'h210e;
  localparam logic [63:0] IEB_IMPL_ALL = {IEB_IMPL_G4, IEB_IMPL_G3, IEB_IMPL_G2, IEB_IMPL_G1};

  // Register word indexes; byte address is index times four
  localparam logic [3:0]  IEB_IDX_EN_FIRST   = 4'h0;
  localparam logic [3:0]  IEB_IDX_FLAG_FIRST = 4'h4;
  localparam logic [3:0]  IEB_IDX_PRIO_FIRST = 4'h8;
  localparam logic [7:0]  IEB_OFS_EN1   = 8'h00;
  localparam logic [7:0]  IEB_OFS_EN2   = 8'h04;
  localparam logic [7:0]  IEB_OFS_EN3   = 8'h08;
  localparam logic [7:0]  IEB_OFS_EN4   = 8'h0c;
  localparam logic [7:0]  IEB_OFS_FLAG1 = 8'h10;
  localparam logic [7:0]  IEB_OFS_PRIO0 = 8'h20;

  localparam logic [15:0] IEB_EN_RESET   = 16'h0000;
  localparam logic [15:0] IEB_FLAG_RESET = 16'h0000;
  localparam logic [2:0]  IEB_PRIO_RESET = 3'h4;
  localparam logic [2:0]  IEB_PRIO_OFF   = 3'h0;

  // Group 1 field positions
  localparam int UART2_TRANSMIT_ENABLE = 15;
  localparam int UART2_RECEIVE_ENABLE  = 14;
  localparam int EXTERNAL_IRQ2_ENABLE  = 13;
  localparam int TIMER5_ENABLE         = 12;
  localparam int TIMER4_ENABLE         = 11;
  localparam int COMPARE4_ENABLE       = 10;
  localparam int COMPARE3_ENABLE       = 9;
  localparam int CAPTURE8_ENABLE       = 7;
  localparam int CAPTURE7_ENABLE       = 6;
  localparam int EXTERNAL_IRQ1_ENABLE  = 4;
  localparam int CHANGE_NOTIFY_ENABLE  = 3;
  localparam int COMPARATOR_ENABLE     = 2;
  localparam int I2C1_MASTER_ENABLE    = 1;
  localparam int I2C1_SLAVE_ENABLE     = 0;
  // Group 2 field positions
  localparam int PARALLEL_PORT_ENABLE  = 13;
  localparam int COMPARE8_ENABLE       = 12;
  localparam int COMPARE5_ENABLE       = 9;
  localparam int CAPTURE6_ENABLE       = 8;
  localparam int CAPTURE3_ENABLE       = 5;
  localparam int SPI2_EVENT_ENABLE     = 1;
  localparam int SPI2_FAULT_ENABLE     = 0;
  // Group 3 field positions
  localparam int CALENDAR_CLOCK_ENABLE = 14;
  localparam int EXTERNAL_IRQ4_ENABLE  = 6;
  localparam int EXTERNAL_IRQ3_ENABLE  = 5;
  localparam int I2C2_MASTER_ENABLE    = 2;
  localparam int I2C2_SLAVE_ENABLE     = 1;
  // Group 4 field positions
  localparam int CHARGE_TIME_ENABLE        = 13;
  localparam int LOW_VOLTAGE_ENABLE        = 8;
  localparam int CHECKSUM_GENERATOR_ENABLE = 3;
  localparam int UART2_ERROR_ENABLE        = 2;
  localparam int UART1_ERROR_ENABLE        = 1;

endpackage

// *** verification/ieb_interrupt_enable_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ieb_interrupt_enable_bank_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [63:0] src_event;
  logic [63:0] req_out;
  logic [2:0]  irq_level;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          n_compared = 0;

  always #2 pclk = ~pclk;

  ieb_interrupt_enable_bank dut (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .src_event (src_event),
    .req_out   (req_out),
    .irq_level (irq_level),
    .irq       (irq)
  );

  ieb_source_model src (
    .pclk      (pclk),
    .src_event (src_event)
  );

  task automatic stop_test;
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      failures++;
      stop_test();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Two edges: flag, then forwarded request
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic sc_regs;
    logic [15:0] mask [4];
    mask = '{16'hfedf, 16'h3fe3, 16'h4066, 16'h210e};
    for (int g = 0; g < 4; g++) begin
      apb(1'b0, 8'(4 * g), 32'h0);
      chk(rd, 64'h0);
      apb(1'b1, 8'(4 * g), 32'hffff_ffff);
      apb(1'b0, 8'(4 * g), 32'h0);
      chk(rd, {48'h0, mask[g]});
      apb(1'b1, 8'(4 * g), 32'h0);
      apb(1'b0, 8'(4 * g), 32'h0);
      chk(rd, 64'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, 64'h1_0000_0000);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    chk(err, 64'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 64'h0);
  endtask

  task automatic sc_gate;
    apb(1'b1, 8'h00, 32'h0000_2000);
    src.pulse(13);
    src.pulse(8);
    settle();
    chk(req_out, 64'h2000);
    chk({irq, irq_level}, 64'hc);
    apb(1'b1, 8'h00, 32'h0);
    settle();
    chk(req_out, 64'h0);
    chk(irq, 64'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 64'h2000);
    apb(1'b1, 8'h00, 32'h0000_2000);
    settle();
    chk(req_out, 64'h2000);
    apb(1'b1, 8'h10, 32'h0000_2000);
    settle();
    chk(irq, 64'h0);
  endtask

  // Sources 13 and 14 share priority word 1
  task automatic sc_prio;
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 64'h4404_4444);
    apb(1'b1, 8'h00, 32'h0000_6000);
    apb(1'b1, 8'h24, 32'h0);
    src.pulse(13);
    settle();
    chk(req_out, 64'h0);
    apb(1'b1, 8'h24, 32'h0270_0000);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 64'h0270_0000);
    src.pulse(14);
    settle();
    chk(req_out, 64'h6000);
    chk({irq, irq_level}, 64'hf);
    apb(1'b1, 8'h10, 32'h0000_6000);
    settle();
    chk(irq, 64'h0);
  endtask

  // Event and write-one clear on the same edge: the event wins
  task automatic sc_race;
    apb(1'b1, 8'h00, 32'h0000_0001);
    src.pulse(0);
    settle();
    chk(req_out, 64'h1);
    fork
      apb(1'b1, 8'h10, 32'h0000_0001);
      begin
        @(posedge pclk);
        src.pulse(0);
      end
    join
    settle();
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 64'h1);
    chk(req_out, 64'h1);
    apb(1'b1, 8'h10, 32'h0000_0001);
    settle();
    chk(irq, 64'h0);
  endtask

  // Sources in groups 2 to 4; bit 0 of group 3 has none
  task automatic sc_groups;
    apb(1'b1, 8'h04, 32'h0000_ffff);
    apb(1'b1, 8'h08, 32'h0000_ffff);
    apb(1'b1, 8'h0c, 32'h0000_2000);
    src.pulse(29);
    src.pulse(32);
    src.pulse(46);
    src.pulse(61);
    settle();
    chk(req_out, 64'h2000_4000_2000_0000);
    chk({irq, irq_level}, 64'hc);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 64'h4000);
  endtask

  // Reset in mid-run with enables, flags and priorities changed
  task automatic sc_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({irq, irq_level}, 64'h0);
    chk(req_out, 64'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 64'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 64'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 64'h4444_4440);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    sc_regs();
    sc_gate();
    sc_prio();
    sc_race();
    sc_groups();
    sc_reset();
    stop_test();
  end
endmodule
`default_nettype wire

// *** verification/ieb_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ieb_source_model (
  input  wire logic        pclk,
  output logic      [63:0] src_event
);
  initial src_event = 64'h0;

  // One-cycle request from source k
  task automatic pulse(input int k);
    @(posedge pclk);
    src_event[k] <= 1'b1;
    @(posedge pclk);
    src_event[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire
